// ### src/bera_top.sv
// Contract
// - Count one error per mismatching bit.
// - Ratio equals errors divided by bits.
// - Keep ratio, errors, ones, zeros, time.
// - Clear when stopped zeroes all results except the instantaneous ratio.
// - Instantaneous ratio refreshes at fixed rate.
// - Stop at limit; manual mode uses commands.
// - Generator output disabled until enabled.
// - Clock rate is half bit rate.
// - Head-side rate and jitter entries halved; limit kept as typed.
// - Keypad value waits for accept key or unit key.
// - Encoder steps take effect at once.
// - No sync before a pattern chosen.
`include "bera_regs.svh"
`default_nettype none
module bera_top #(
  parameter int unsigned CW = 32,
  parameter int unsigned TICK_CYC = `BERA_TICK_CYC,
  parameter int unsigned INSTANTANEOUS_ERROR_RATIO_CYC = `BERA_INSTANTANEOUS_ERROR_RATIO_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Returned bitstream pins
  input wire logic rx_bit_pin,
  input wire logic rx_strobe_pin,
  // Pattern and measurement control
  input wire bera_pkg::bera_pat_t pat_sel,
  input wire logic sync_req,
  input wire logic out_enable,
  input wire bera_pkg::bera_stop_t stop_mode,
  input wire logic start_cmd,
  input wire logic stop_cmd,
  input wire logic clear_cmd,
  // Parameter entry
  input wire logic [3:0] key_digit,
  input wire logic key_strobe,
  input wire logic entry_accept_key,
  input wire logic unit_key,
  input wire logic enc_up,
  input wire logic enc_dn,
  input wire bera_pkg::bera_field_t field_sel,
  input wire logic pat_side,
  // Pattern generator output
  output logic pg_data,
  output logic pg_data_oe,
  // Results
  output logic synced,
  output logic running,
  output logic [CW-1:0] bit_count,
  output logic [CW-1:0] err_count,
  output logic [CW-1:0] err1_count,
  output logic [CW-1:0] err0_count,
  output logic [CW-1:0] elapsed,
  output logic [`BERA_RATIO_W-1:0] accumulated_error_ratio,
  output logic [`BERA_RATIO_W-1:0] instantaneous_error_ratio,
  // Committed settings
  output logic [CW-1:0] clk_rate,
  output logic [CW-1:0] bit_rate,
  output logic [CW-1:0] jitter_clk,
  output logic [CW-1:0] jitter_pat,
  output logic [CW-1:0] limit
);
  import bera_pkg::*;
  localparam int unsigned F = `BERA_RATIO_W;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  function automatic logic [CW-1:0] bera_sat_inc(input logic [CW-1:0] v, input logic en);
    return (en && v != '1) ? v + 1'b1 : v;
  endfunction : bera_sat_inc

  function automatic logic [6:0] bera_prbs(input logic [6:0] s);
    return {s[5:0], s[`BERA_TAP_HI] ^ s[`BERA_TAP_LO]};
  endfunction : bera_prbs

  bera_cfg_if #(.W(CW)) cfg ();
  bera_entry #(.W(CW)) u_entry (
    .mclk(mclk), .resetn(resetn), .key_digit(key_digit), .key_strobe(key_strobe),
    .entry_accept_key(entry_accept_key), .unit_key(unit_key), .enc_up(enc_up),
    .enc_dn(enc_dn), .field_sel(field_sel), .pat_side(pat_side), .cfg(cfg)
  );
  assign clk_rate = cfg.clk_rate;
  assign bit_rate = cfg.bit_rate;
  assign jitter_clk = cfg.jitter_clk;
  assign jitter_pat = cfg.jitter_pat;
  assign limit = cfg.limit;

  // The first stage only feeds the second, so metastability never reaches logic.
  logic rx_bit_m, rx_bit, rx_stb_m, rx_stb;
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rx_bit_m <= 1'b0;
      rx_bit <= 1'b0;
      rx_stb_m <= 1'b0;
      rx_stb <= 1'b0;
    end else begin
      rx_bit_m <= rx_bit_pin;
      rx_bit <= rx_bit_m;
      rx_stb_m <= rx_strobe_pin;
      rx_stb <= rx_stb_m;
    end
  end

  bera_state_t state, next_state;
  logic [6:0] ref_lfsr, gen_lfsr, next_ref_lfsr, next_gen_lfsr;
  logic ref_alt, gen_alt, next_ref_alt, next_gen_alt, next_synced, next_pg_data;
  logic [CW-1:0] next_bits, next_errs, next_err1, next_err0, next_elapsed;
  logic [31:0] tick_cnt, win_cnt, next_tick_cnt, next_win_cnt;
  logic [CW-1:0] win_err, win_bits, win_err_q, win_bits_q;
  logic [CW-1:0] next_win_err, next_win_bits, next_win_err_q, next_win_bits_q;
  logic ref_bit, bit_ok, mism, counting, clear_ok, limit_hit, time_tick, win_tick;

  always_comb begin
    ref_bit = (pat_sel == BERA_PAT_PRBS7) ? ref_lfsr[6] : ref_alt;
    bit_ok = rx_stb && synced;
    mism = bit_ok && (rx_bit != ref_bit);
    counting = (state == BERA_RUNNING);
    clear_ok = clear_cmd && (state == BERA_STOPPED);
    time_tick = counting && (tick_cnt == TICK_CYC - 1);
    win_tick = (win_cnt == INSTANTANEOUS_ERROR_RATIO_CYC - 1);
    next_tick_cnt = clear_ok ? '0 : (time_tick ? '0 : tick_cnt + (counting ? 1 : 0));
    next_win_cnt = win_tick ? '0 : win_cnt + 1;
    // Reference advances only on received bits, so it stays bit-aligned once seeded.
    next_ref_lfsr = bit_ok ? bera_prbs(ref_lfsr) : ref_lfsr;
    next_ref_alt = bit_ok ? ~ref_alt : ref_alt;
    next_synced = synced;
    if (pat_sel == BERA_PAT_NONE) begin
      next_synced = 1'b0;
    end else if (sync_req) begin
      next_synced = 1'b1;
      next_ref_lfsr = `BERA_SEED;
      next_ref_alt = 1'b1;
    end
    next_gen_lfsr = bera_prbs(gen_lfsr);
    next_gen_alt = ~gen_alt;
    next_pg_data = out_enable && ((pat_sel == BERA_PAT_PRBS7) ? gen_lfsr[6] : gen_alt);
    next_bits = bera_sat_inc(bit_count, counting && bit_ok);
    next_errs = bera_sat_inc(err_count, counting && mism);
    next_err1 = bera_sat_inc(err1_count, counting && mism && ref_bit);
    next_err0 = bera_sat_inc(err0_count, counting && mism && !ref_bit);
    next_elapsed = bera_sat_inc(elapsed, time_tick);
    if (clear_ok) begin
      next_bits = '0;
      next_errs = '0;
      next_err1 = '0;
      next_err0 = '0;
      next_elapsed = '0;
    end
    case (stop_mode)
      BERA_BY_TIME: limit_hit = next_elapsed >= limit;
      BERA_BY_BITS: limit_hit = next_bits >= limit;
      BERA_BY_ERRS: limit_hit = next_errs >= limit;
      default: limit_hit = 1'b0;
    endcase
    case (state)
      BERA_STOPPED: next_state = start_cmd ? BERA_RUNNING : BERA_STOPPED;
      BERA_RUNNING: next_state = (stop_cmd || limit_hit) ? BERA_STOPPED : BERA_RUNNING;
      default: next_state = BERA_STOPPED;
    endcase
    // A bit seen on the tick cycle opens the next window, so none is lost between windows.
    next_win_err = bera_sat_inc(win_tick ? '0 : win_err, mism);
    next_win_bits = bera_sat_inc(win_tick ? '0 : win_bits, bit_ok);
    next_win_err_q = win_tick ? win_err : win_err_q;
    next_win_bits_q = win_tick ? win_bits : win_bits_q;
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state <= BERA_STOPPED;
      synced <= 1'b0;
      ref_lfsr <= `BERA_SEED;
      ref_alt <= 1'b1;
      gen_lfsr <= `BERA_SEED;
      gen_alt <= 1'b1;
      pg_data <= 1'b0;
      pg_data_oe <= 1'b0;
      bit_count <= '0;
      err_count <= '0;
      err1_count <= '0;
      err0_count <= '0;
      elapsed <= '0;
      tick_cnt <= '0;
      win_cnt <= '0;
      win_err <= '0;
      win_bits <= '0;
      win_err_q <= '0;
      win_bits_q <= '0;
    end else begin
      state <= next_state;
      synced <= next_synced;
      ref_lfsr <= next_ref_lfsr;
      ref_alt <= next_ref_alt;
      gen_lfsr <= next_gen_lfsr;
      gen_alt <= next_gen_alt;
      pg_data <= next_pg_data;
      pg_data_oe <= out_enable;
      bit_count <= next_bits;
      err_count <= next_errs;
      err1_count <= next_err1;
      err0_count <= next_err0;
      elapsed <= next_elapsed;
      tick_cnt <= next_tick_cnt;
      win_cnt <= next_win_cnt;
      win_err <= next_win_err;
      win_bits <= next_win_bits;
      win_err_q <= next_win_err_q;
      win_bits_q <= next_win_bits_q;
    end
  end
  assign running = (state == BERA_RUNNING);

  // One shared serial divider alternates between the two ratios; this costs
  // F + 1 cycles per result but avoids two wide array dividers.
  logic [5:0] div_cnt, next_div_cnt;
  logic [CW:0] div_rem, next_div_rem, div_t;
  logic [CW-1:0] div_den, next_div_den;
  logic [F-1:0] div_q, next_div_q, next_acc, next_inst;
  logic div_sel, div_zero, next_div_sel, next_div_zero;

  always_comb begin
    next_div_cnt = div_cnt;
    next_div_rem = div_rem;
    next_div_den = div_den;
    next_div_q = div_q;
    next_div_sel = div_sel;
    next_div_zero = div_zero;
    next_acc = accumulated_error_ratio;
    next_inst = instantaneous_error_ratio;
    div_t = {div_rem[CW-1:0], 1'b0};
    if (clear_ok) begin
      next_div_cnt = '0;
      next_acc = '0;
    end else if (div_cnt == '0) begin
      next_div_rem = {1'b0, div_sel ? win_err_q : err_count};
      next_div_den = div_sel ? win_bits_q : bit_count;
      next_div_zero = div_sel ? (win_bits_q == '0) : (bit_count == '0);
      next_div_q = '0;
      next_div_cnt = 6'h01;
    end else begin
      if (div_t >= {1'b0, div_den}) begin
        next_div_rem = div_t - {1'b0, div_den};
        next_div_q = {div_q[F-2:0], 1'b1};
      end else begin
        next_div_rem = div_t;
        next_div_q = {div_q[F-2:0], 1'b0};
      end
      if (div_cnt == 6'(F)) begin
        next_div_cnt = '0;
        next_div_sel = ~div_sel;
        if (div_sel) begin
          next_inst = div_zero ? '0 : next_div_q;
        end else begin
          next_acc = div_zero ? '0 : next_div_q;
        end
      end else begin
        next_div_cnt = div_cnt + 6'h01;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      div_cnt <= '0;
      div_rem <= '0;
      div_den <= '0;
      div_q <= '0;
      div_sel <= 1'b0;
      div_zero <= 1'b1;
      accumulated_error_ratio <= '0;
      instantaneous_error_ratio <= '0;
    end else begin
      div_cnt <= next_div_cnt;
      div_rem <= next_div_rem;
      div_den <= next_div_den;
      div_q <= next_div_q;
      div_sel <= next_div_sel;
      div_zero <= next_div_zero;
      accumulated_error_ratio <= next_acc;
      instantaneous_error_ratio <= next_inst;
    end
  end

  property p_err_inc;
    counting && mism && !clear_ok && err_count != '1 |=> err_count == $past(err_count) + 1'b1;
  endproperty
  a_err_inc: assert property (p_err_inc) else $error("error not counted");
  property p_err_split;
    err_count != '1 |-> err_count == err1_count + err0_count;
  endproperty
  a_err_split: assert property (p_err_split) else $error("error split mismatch");
  property p_clear;
    clear_ok |=> bit_count == '0 && err_count == '0 && elapsed == '0
      && accumulated_error_ratio == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("clear left results");
  property p_sat;
    err_count == '1 && !clear_ok |=> err_count == '1;
  endproperty
  a_sat: assert property (p_sat) else $error("counter wrapped");
  property p_bit_limit;
    counting && stop_mode == BERA_BY_BITS && next_bits >= limit |=> !running;
  endproperty
  a_bit_limit: assert property (p_bit_limit) else $error("bit limit ignored");
  property p_manual_hold;
    !running && !start_cmd |=> !running;
  endproperty
  a_manual_hold: assert property (p_manual_hold) else $error("started by itself");
  property p_oe_off;
    !out_enable |=> !pg_data_oe && !pg_data;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("output driven while disabled");
  property p_no_sync;
    pat_sel == BERA_PAT_NONE |=> !synced;
  endproperty
  a_no_sync: assert property (p_no_sync) else $error("synced without pattern");
  property p_win_hold;
    !win_tick |=> $stable(win_err_q) && $stable(win_bits_q);
  endproperty
  a_win_hold: assert property (p_win_hold) else $error("window moved off tick");
  property p_zero_ratio;
    div_cnt == 6'(F) && div_zero && !div_sel && !clear_ok |=> accumulated_error_ratio == '0;
  endproperty
  a_zero_ratio: assert property (p_zero_ratio) else $error("ratio with no bits");
  c_run_limit: cover property (running && stop_mode == BERA_BY_ERRS ##1 !running);
  c_clear: cover property (clear_ok && err_count != '0);
  c_sync: cover property (sync_req && pat_sel == BERA_PAT_PRBS7 ##1 synced);
  c_win: cover property (win_tick && win_err != '0);
endmodule : bera_top
`default_nettype wire

// ### include/bera_regs.svh
`ifndef BERA_REGS_SVH
`define BERA_REGS_SVH
`define BERA_CLK_NS 100
`define BERA_TICK_NS 1000000
`define BERA_INSTANTANEOUS_ERROR_RATIO_NS 100000000
`define BERA_TICK_CYC ((`BERA_TICK_NS + `BERA_CLK_NS - 1) / `BERA_CLK_NS)
`define BERA_INSTANTANEOUS_ERROR_RATIO_CYC (`BERA_INSTANTANEOUS_ERROR_RATIO_NS / `BERA_CLK_NS)
`define BERA_SEED 7'h7F
`define BERA_TAP_HI 6
`define BERA_TAP_LO 5
`define BERA_RATIO_W 32
`define BERA_DEC_BASE 32'h0000000A
`define BERA_CFG_RST 32'h00000000
`endif

// ### include/bera_pkg.sv
`default_nettype none
package bera_pkg;
  typedef enum logic [1:0] {BERA_STOPPED = 2'b01, BERA_RUNNING = 2'b10} bera_state_t;
  typedef enum logic [1:0] {
    BERA_MANUAL = 2'h0, BERA_BY_TIME = 2'h1, BERA_BY_BITS = 2'h2, BERA_BY_ERRS = 2'h3
  } bera_stop_t;
  typedef enum logic [1:0] {
    BERA_PAT_NONE = 2'h0, BERA_PAT_PRBS7 = 2'h1, BERA_PAT_CLOCK = 2'h2
  } bera_pat_t;
  typedef enum logic [1:0] {
    BERA_F_RATE = 2'h0, BERA_F_JIT = 2'h1, BERA_F_LIMIT = 2'h2
  } bera_field_t;
endpackage : bera_pkg
`default_nettype wire

// ### include/bera_cfg_if.sv
`default_nettype none
interface bera_cfg_if #(parameter int unsigned W = 32);
  logic [W-1:0] clk_rate;
  logic [W-1:0] bit_rate;
  logic [W-1:0] jitter_clk;
  logic [W-1:0] jitter_pat;
  logic [W-1:0] limit;
  modport src (output clk_rate, output bit_rate, output jitter_clk, output jitter_pat,
               output limit);
  modport dst (input clk_rate, input bit_rate, input jitter_clk, input jitter_pat,
               input limit);
endinterface : bera_cfg_if
`default_nettype wire

// ### src/bera_entry.sv
`include "bera_regs.svh"
`default_nettype none
module bera_entry #(parameter int unsigned W = 32) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Panel events, one-cycle pulses from the panel scanner
  input wire logic [3:0] key_digit,
  input wire logic key_strobe,
  input wire logic entry_accept_key,
  input wire logic unit_key,
  input wire logic enc_up,
  input wire logic enc_dn,
  input wire bera_pkg::bera_field_t field_sel,
  input wire logic pat_side,
  // Committed settings
  bera_cfg_if.src cfg
);
  import bera_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  logic [W-1:0] pending, clk_rate, jit, lim, bit_rate, jit_pat;
  logic [W-1:0] next_pending, next_clk, next_jit, next_lim, val;
  logic commit, step;

  always_comb begin
    next_pending = pending;
    next_clk = clk_rate;
    next_jit = jit;
    next_lim = lim;
    commit = entry_accept_key || unit_key;
    step = enc_up ^ enc_dn;
    // Remote heads run at twice the clock rate, so head-side rate and jitter values are halved; the limit is not.
    val = (pat_side && field_sel != BERA_F_LIMIT) ? (pending >> 1) : pending;
    if (commit) begin
      next_pending = '0;
      case (field_sel)
        BERA_F_RATE: next_clk = val;
        BERA_F_JIT: next_jit = val;
        BERA_F_LIMIT: next_lim = val;
        default: next_lim = lim;
      endcase
    end else if (key_strobe) begin
      next_pending = W'(pending * `BERA_DEC_BASE + {28'h0000000, key_digit});
    end else if (step) begin
      case (field_sel)
        BERA_F_RATE: next_clk = enc_up ? clk_rate + 1'b1 : clk_rate - 1'b1;
        BERA_F_JIT: next_jit = enc_up ? jit + 1'b1 : jit - 1'b1;
        BERA_F_LIMIT: next_lim = enc_up ? lim + 1'b1 : lim - 1'b1;
        default: next_lim = lim;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pending <= '0;
      clk_rate <= `BERA_CFG_RST;
      jit <= `BERA_CFG_RST;
      lim <= `BERA_CFG_RST;
      bit_rate <= `BERA_CFG_RST;
      jit_pat <= `BERA_CFG_RST;
    end else begin
      pending <= next_pending;
      clk_rate <= next_clk;
      jit <= next_jit;
      lim <= next_lim;
      bit_rate <= {next_clk[W-2:0], 1'b0};
      jit_pat <= {next_jit[W-2:0], 1'b0};
    end
  end

  assign cfg.clk_rate = clk_rate;
  assign cfg.bit_rate = bit_rate;
  assign cfg.jitter_clk = jit;
  assign cfg.jitter_pat = jit_pat;
  assign cfg.limit = lim;

  property p_pending_holds;
    !entry_accept_key && !unit_key && !step |=> $stable(clk_rate) && $stable(lim);
  endproperty
  a_pending_holds: assert property (p_pending_holds) else $error("setting moved");
  property p_enc_now;
    enc_up && !enc_dn && !commit && !key_strobe && field_sel == BERA_F_RATE
      |=> clk_rate == $past(clk_rate) + 1'b1;
  endproperty
  a_enc_now: assert property (p_enc_now) else $error("encoder not applied");
  property p_half_scale;
    commit && pat_side && field_sel == BERA_F_RATE |=> clk_rate == ($past(pending) >> 1);
  endproperty
  a_half_scale: assert property (p_half_scale) else $error("head value not halved");
  property p_double_rate;
    bit_rate == {clk_rate[W-2:0], 1'b0} && jit_pat == {jit[W-2:0], 1'b0};
  endproperty
  a_double_rate: assert property (p_double_rate) else $error("rate not doubled");
  c_commit: cover property (key_strobe ##[1:8] entry_accept_key);
endmodule : bera_entry
`default_nettype wire

// ### dv/bera_dut_model.sv
`default_nettype none
module bera_dut_model (
  // Clock
  input wire logic mclk,
  // Generator output seen by the device under test
  input wire logic pg_data,
  input wire logic pg_data_oe,
  // Returned stream
  output logic rx_bit_pin,
  output logic rx_strobe_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic in_frame = 1'b0;
  initial begin
    rx_bit_pin = 1'b0;
    rx_strobe_pin = 1'b0;
  end
  // Between frames the line is released, so it shows a value that changes every cycle.
  always @(posedge mclk) begin
    #10;
    if (!in_frame) begin
      rx_bit_pin = ~rx_bit_pin;
    end
  end
  // Sends n bits: a fixed level, or the generator output looped back, or a toggling bit when looped while the output is disabled.
  task automatic burst(input int n, input logic val, input logic loop);
    in_frame = 1'b1;
    repeat (n) begin
      @(posedge mclk);
      #10;
      rx_strobe_pin = 1'b1;
      rx_bit_pin = loop ? (pg_data_oe ? pg_data : ~rx_bit_pin) : val;
    end
    @(posedge mclk);
    #10;
    rx_strobe_pin = 1'b0;
    in_frame = 1'b0;
  endtask : burst
endmodule : bera_dut_model
`default_nettype wire

// ### dv/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import bera_pkg::*;
  localparam int unsigned TICK = 10;
  localparam int unsigned INSTANTANEOUS_ERROR_RATIO = 200;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic rx_bit_pin, rx_strobe_pin;
  bera_pat_t pat_sel = BERA_PAT_NONE;
  bera_stop_t stop_mode = BERA_MANUAL;
  bera_field_t field_sel = BERA_F_RATE;
  logic sync_req = 1'b0, out_enable = 1'b0, start_cmd = 1'b0, stop_cmd = 1'b0;
  logic clear_cmd = 1'b0, key_strobe = 1'b0, entry_accept_key = 1'b0, unit_key = 1'b0;
  logic enc_up = 1'b0, enc_dn = 1'b0, pat_side = 1'b0;
  logic [3:0] key_digit = 4'h0;
  logic pg_data, pg_data_oe, synced, running;
  logic [31:0] bit_count, err_count, err1_count, err0_count, elapsed;
  logic [31:0] accumulated_error_ratio, instantaneous_error_ratio;
  logic [31:0] clk_rate, bit_rate, jitter_clk, jitter_pat, limit;
  int fail_count = 0;
  int tests_run = 0;
  always #50 mclk = ~mclk;
  bera_top #(.CW(32), .TICK_CYC(TICK), .INSTANTANEOUS_ERROR_RATIO_CYC(INSTANTANEOUS_ERROR_RATIO)) dut (
    .mclk(mclk), .resetn(resetn), .rx_bit_pin(rx_bit_pin), .rx_strobe_pin(rx_strobe_pin),
    .pat_sel(pat_sel), .sync_req(sync_req), .out_enable(out_enable), .stop_mode(stop_mode),
    .start_cmd(start_cmd), .stop_cmd(stop_cmd), .clear_cmd(clear_cmd),
    .key_digit(key_digit), .key_strobe(key_strobe), .entry_accept_key(entry_accept_key),
    .unit_key(unit_key), .enc_up(enc_up), .enc_dn(enc_dn), .field_sel(field_sel),
    .pat_side(pat_side), .pg_data(pg_data), .pg_data_oe(pg_data_oe), .synced(synced),
    .running(running), .bit_count(bit_count), .err_count(err_count),
    .err1_count(err1_count), .err0_count(err0_count), .elapsed(elapsed),
    .accumulated_error_ratio(accumulated_error_ratio),
    .instantaneous_error_ratio(instantaneous_error_ratio), .clk_rate(clk_rate),
    .bit_rate(bit_rate), .jitter_clk(jitter_clk), .jitter_pat(jitter_pat), .limit(limit));
  bera_dut_model model (.mclk(mclk), .pg_data(pg_data), .pg_data_oe(pg_data_oe),
    .rx_bit_pin(rx_bit_pin), .rx_strobe_pin(rx_strobe_pin));

  task automatic step();
    @(posedge mclk);
    #10;
  endtask : step

  task automatic summarize();
    if (fail_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic chk_rng(input logic [31:0] got, input int lo, input int hi, input string what);
    tests_run++;
    if ((^got === 1'bx) || got < lo || got > hi) begin
      fail_count++;
      $display("[ERR] %0t %s got %0d outside %0d..%0d", $time, what, got, lo, hi);
    end
  endtask : chk_rng

  // The extra edge after lowering keeps a repeated pulse from toggling in one time step.
  task automatic pulse(ref logic s);
    s = 1'b1;
    step();
    s = 1'b0;
    step();
  endtask : pulse

  task automatic type_val(input bera_field_t f, input logic side, input int v);
    int d[$];
    field_sel = f;
    pat_side = side;
    do begin
      d.push_front(v % 10);
      v = v / 10;
    end while (v > 0);
    foreach (d[i]) begin
      key_digit = d[i][3:0];
      pulse(key_strobe);
    end
  endtask : type_val

  task automatic wait_stop(input int max);
    int n;
    n = 0;
    while (running !== 1'b0 && n < max) begin
      step();
      n++;
    end
    if (n >= max) begin
      fail_count++;
      $display("[ERR] %0t measurement did not stop", $time);
      summarize();
    end
  endtask : wait_stop

  task automatic t_reset();
    chk(pg_data_oe, 1'b0, "oe after reset");
    chk(pg_data, 1'b0, "data after reset");
    chk(running, 1'b0, "running after reset");
    chk(synced, 1'b0, "synced after reset");
    chk(bit_count, 32'h0, "bits after reset");
    chk(accumulated_error_ratio, 32'h0, "ratio after reset");
  endtask : t_reset

  task automatic t_entry();
    type_val(BERA_F_RATE, 1'b1, 2000);
    chk(clk_rate, 32'h0, "pending rate");
    pulse(entry_accept_key);
    chk(clk_rate, 32'd1000, "head rate");
    chk(bit_rate, 32'd2000, "bit rate");
    type_val(BERA_F_RATE, 1'b0, 700);
    pulse(unit_key);
    chk(clk_rate, 32'd700, "clock rate");
    chk(bit_rate, 32'd1400, "bit rate");
    pulse(enc_up);
    chk(clk_rate, 32'd701, "encoder rate");
    chk(bit_rate, 32'd1402, "encoder bit rate");
    type_val(BERA_F_JIT, 1'b1, 7);
    pulse(entry_accept_key);
    chk(jitter_clk, 32'd3, "head jitter");
    chk(jitter_pat, 32'd6, "pattern jitter");
    type_val(BERA_F_LIMIT, 1'b1, 40);
    pulse(entry_accept_key);
    chk(limit, 32'd40, "limit");
    enc_up = 1'b1;
    step();
    enc_up = 1'b0;
    chk(limit, 32'd41, "encoder up");
    pulse(enc_dn);
    chk(limit, 32'd40, "encoder down");
  endtask : t_entry

  task automatic t_setup();
    logic b;
    step();
    step();
    chk(pg_data_oe, 1'b0, "oe before enable");
    pat_sel = BERA_PAT_NONE;
    pulse(sync_req);
    chk(synced, 1'b0, "sync without pattern");
    pat_sel = BERA_PAT_CLOCK;
    out_enable = 1'b1;
    step();
    step();
    chk(pg_data_oe, 1'b1, "oe after enable");
    b = pg_data;
    step();
    chk(pg_data, {31'h0, ~b}, "clock pattern");
    model.burst(16, 1'b0, 1'b1);
    pulse(sync_req);
    chk(synced, 1'b1, "sync with pattern");
  endtask : t_setup

  task automatic t_manual();
    int t0, c;
    stop_mode = BERA_MANUAL;
    t0 = int'($time);
    pulse(start_cmd);
    chk(running, 1'b1, "started");
    model.burst(100, 1'b0, 1'b0);
    repeat (4) step();
    chk(bit_count, 32'd100, "bits");
    chk(err_count, 32'd50, "errors");
    chk(err1_count, 32'd50, "errors on one");
    chk(err0_count, 32'd0, "errors on zero");
    model.burst(100, 1'b1, 1'b0);
    repeat (4) step();
    chk(err_count, 32'd100, "errors");
    chk(err0_count, 32'd50, "errors on zero");
    chk(running, 1'b1, "manual keeps running");
    pulse(clear_cmd);
    chk(err_count, 32'd100, "clear while running");
    c = (int'($time) - t0) / 100;
    pulse(stop_cmd);
    chk(running, 1'b0, "stopped");
    chk_rng(elapsed, c / TICK - 1, c / TICK + 2, "elapsed");
    repeat (140) step();
    chk(accumulated_error_ratio, 32'h80000000, "ratio");
    pulse(clear_cmd);
    chk(bit_count, 32'h0, "cleared bits");
    chk(err_count, 32'h0, "cleared errors");
    chk(err1_count, 32'h0, "cleared ones");
    chk(err0_count, 32'h0, "cleared zeros");
    chk(elapsed, 32'h0, "cleared time");
    chk(accumulated_error_ratio, 32'h0, "cleared ratio");
  endtask : t_manual

  task automatic t_limits();
    bera_stop_t m[3] = '{BERA_BY_BITS, BERA_BY_ERRS, BERA_BY_TIME};
    int lim[3] = '{40, 40, 5};
    foreach (m[i]) begin
      type_val(BERA_F_LIMIT, 1'b0, lim[i]);
      pulse(entry_accept_key);
      stop_mode = m[i];
      pulse(start_cmd);
      model.burst(200, 1'b0, 1'b0);
      wait_stop(20);
      case (i)
        0: chk(bit_count, lim[i], "bit limit");
        1: chk(err_count, lim[i], "error limit");
        default: chk(elapsed, lim[i], "time limit");
      endcase
      pulse(clear_cmd);
    end
  endtask : t_limits

  task automatic t_inst();
    fork
      model.burst(700, 1'b0, 1'b0);
      begin
        repeat (650) step();
        chk(running, 1'b0, "still stopped");
        chk(instantaneous_error_ratio, 32'h80000000, "instant ratio");
      end
    join
  endtask : t_inst

  // One full period of the seven-bit sequence holds 64 ones and 63 zeros, whatever its phase.
  task automatic t_prbs();
    pat_sel = BERA_PAT_PRBS7;
    stop_mode = BERA_MANUAL;
    repeat (4) step();
    pulse(sync_req);
    chk(synced, 1'b1, "sync on sequence");
    pulse(clear_cmd);
    pulse(start_cmd);
    model.burst(127, 1'b0, 1'b0);
    repeat (4) step();
    pulse(stop_cmd);
    chk(bit_count, 32'd127, "sequence bits");
    chk(err_count, 32'd64, "sequence errors");
    chk(err1_count, 32'd64, "sequence errors on one");
    chk(err0_count, 32'd0, "sequence errors on zero");
  endtask : t_prbs

  initial begin
    repeat (3) @(posedge mclk);
    #10;
    resetn = 1'b1;
    t_reset();
    t_entry();
    t_setup();
    t_manual();
    t_limits();
    t_inst();
    t_prbs();
    summarize();
  end
endmodule : tb
`default_nettype wire
